// ---- design/scd_decoder.sv ----
// Instruction decode and execution control of the stack processor.
// Assumes bytes arrive from fetch on mclk; haltProbe is an async pin.
//
// Contract
// [RULE1] Byte splits into function nibble and operand nibble
// [RULE2] Positive prefix adds four operand bits
// [RULE3] Negative prefix complements accumulated operand first
// [RULE4] Operate selects operation by accumulated operand
// [RULE5] Prefixes shift accumulator; others consume, clear
// [RULE6] Branch 2 or 4 cycles; jump 3
// [RULE7] Only listed instructions are descheduling points
// [RULE8] Halt probe stops only at descheduling points
// [RULE9] Only listed instructions change process fault
// [RULE10] Armed zero jump swaps pointer pair
// [RULE11] Break neither deschedules nor alters stack
// [RULE12] Break instructions combine into single stepping
// [RULE13] Block move uses minimal word steps
// [RULE14] Interrupted move finishes to word boundary
// [RULE15] Resume rewrites last word unless skipped
// [RULE16] IEEE exceptions set float fault
// [RULE17] Infinite or NaN inputs set float fault
// [RULE18] Float fault independent; propagate sets process fault
// [RULE19] Only listed instructions change float fault
// [RULE20] Timed choice wait 48 or 15
// [RULE21] Choice wait 5 or 17
// [RULE22] Channel guard 7 or 5
// [RULE23] Fraction product 35 or 40
// [RULE24] Product b+4 or m+5
// [RULE25] Double shift n+3 or n-28
// [RULE26] Queue save takes 4 cycles
`timescale 1ns/10ps
`default_nettype none
`include "scd_cfg.svh"
module scd_decoder import scd_pkg::*; (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Fetch
  input  wire logic        instrValid,
  input  wire logic [7:0]  instrByte,
  output logic             instrReady_r,
  // Datapath status
  input  wire logic [31:0] aReg,
  input  wire logic [6:0]  shiftCnt,
  input  wire logic        highPri,
  input  wire logic        timePast,
  input  wire logic        chanReady,
  input  wire logic        fmulRound,
  input  wire logic        aluErr,
  input  wire logic        fpExcept,
  input  wire logic        fpNonFinite,
  // Halt probe pin
  input  wire logic        haltProbe,
  // Block move control
  input  wire logic [31:0] moveLen,
  input  wire logic [1:0]  moveDst,
  input  wire logic        moveIrq,
  input  wire logic        moveResume,
  input  wire logic        moveSkipRewrite,
  // Issue results
  output logic             execValid_r,
  output logic [3:0]       funcCode_r,
  output logic [31:0]      operand_r,
  output logic [11:0]      opCode_r,
  output logic [7:0]       cycles_r,
  output logic             deschedPt_r,
  output logic             brkSwap_r,
  output logic             done_r,
  output logic             halted_r,
  // Flags
  output logic             processFault_r,
  output logic             fpFault_r,
  output logic             brkArm_r,
  // Block move steps
  output logic             moveStep_r,
  output logic [2:0]       moveBytes_r,
  output logic             moveRewrite_r,
  output logic             moveSuspended_r
);
  // ========================================
  // Decode functions
  function automatic logic isDesched(input logic [3:0] f, input logic [11:0] op);
    if (f == `SCD_FN_J) return 1'b1;
    if (f != `SCD_FN_OPR) return 1'b0;
    return op inside {OP_IN, OP_OUT, OP_OUTB, OP_OUTW, OP_TALTWT, OP_TIN,
                      OP_STOPERR, OP_ALTWT, OP_LEND, OP_ENDP, OP_STARTP};
  endfunction

  function automatic logic isErrOp(input logic [3:0] f, input logic [11:0] op);
    if (f == `SCD_FN_ADC) return 1'b1;
    if (f != `SCD_FN_OPR) return 1'b0;
    return op inside {OP_ADD, OP_SUB, OP_MUL, OP_FMUL, OP_DIV, OP_REM, OP_LADD,
                      OP_LSUB, OP_LDIV, OP_SETERR, OP_TESTERR, OP_FPCHK, OP_CWORD,
                      OP_CSUB0, OP_CSNGL, OP_CCNT1};
  endfunction

  function automatic logic isFpOp(input logic [11:0] op, input logic [7:0] sel);
    if (op == OP_FPENTRY)
      return sel inside {FS_SQRTF, FS_R32R64, FS_R64R32, FS_EXPDEC, FS_EXPINC, FS_ABS,
                         FS_CHKI32, FS_CHKI64, FS_DIV2, FS_MUL2, FS_SETERR, FS_CLRERR};
    return op inside {OP_FPADD, OP_FPSUB, OP_FPMUL, OP_FPDIV, OP_FPLADDS, OP_FPLADDD,
                      OP_FPLMULS, OP_FPLMULD, OP_FPREMF, OP_FPGT, OP_FPEQ, OP_FPTEST,
                      OP_FPRTOI, OP_FPINT};
  endfunction

  // ========================================
  // Byte decode
  scd_state_t  state_r, stateNxt;
  logic [31:0] operandAcc_r;
  logic [7:0]  cnt_r;
  logic        haltMeta_r, haltSync_r;
  logic        isMove_r;
  logic [31:0] mvRem_r;
  logic [1:0]  mvOff_r;
  logic [2:0]  mvLast_r;
  logic [7:0]  calcCy;

  wire [3:0]  inFunc  = instrByte[7:4]; // [RULE1]
  wire [3:0]  inNib   = instrByte[3:0];
  wire [31:0] accOr   = operandAcc_r | {28'h0, inNib};
  wire        isPfx   = inFunc == `SCD_FN_PFIX;
  wire        isNfx   = inFunc == `SCD_FN_NFIX;
  wire        take    = (state_r == ST_IDLE) && instrValid && instrReady_r;
  wire        issue   = take && !isPfx && !isNfx;
  wire [11:0] inOp    = accOr[11:0]; // [RULE4]
  wire        inOpr   = inFunc == `SCD_FN_OPR;
  wire [7:0]  fsel    = aReg[7:0];
  wire        nDes    = isDesched(inFunc, inOp);
  wire        nErr    = isErrOp(inFunc, inOp);
  wire        nFp     = inOpr && isFpOp(inOp, fsel);
  wire        isBreak = inOpr && inOp == OP_BREAK;
  wire        j0Brk   = inFunc == `SCD_FN_J && accOr == 32'h0 && brkArm_r;
  wire        fpEnt   = inOpr && inOp == OP_FPENTRY;

  // ========================================
  // Flag updates
  wire errSet = issue && ((nErr && aluErr && !(inOpr && inOp inside {OP_TESTERR, OP_FPCHK}))
                          || (inOpr && inOp == OP_SETERR)
                          || (inOpr && inOp == OP_FPCHK && fpFault_r)); // [RULE9] [RULE18]
  wire errClr = issue && inOpr && inOp == OP_TESTERR;
  wire fpSet  = issue && ((nFp && (fpExcept || fpNonFinite)) // [RULE16] [RULE17]
                          || (fpEnt && fsel == FS_SETERR)); // [RULE19]
  wire fpClr  = issue && ((inOpr && inOp == OP_FPTEST) || (fpEnt && fsel == FS_CLRERR));
  wire brkOn  = issue && inOpr && inOp == OP_BRKARM;
  wire brkOff = issue && inOpr && inOp == OP_BRKCLR;

  // ========================================
  // Block move step
  wire [2:0]  room   = 3'h4 - {1'b0, mvOff_r};
  wire [2:0]  stepB  = (mvRem_r < {29'h0, room}) ? mvRem_r[2:0] : room; // [RULE13]
  wire [31:0] remNxt = mvRem_r - {29'h0, stepB};
  wire [1:0]  offNxt = mvOff_r + stepB[1:0];
  wire        mvGo   = state_r == ST_MOVE && mvRem_r != 32'h0;
  wire        mvStop = mvGo && remNxt != 32'h0 && moveIrq && offNxt == 2'h0; // [RULE14]
  wire        resume = state_r == ST_SUSP && moveResume;
  wire        execEnd = state_r == ST_EXEC && cnt_r == 8'h00;

  scd_cycle_calc scd_cycle_calc_inst (
    .funcCode    (inFunc),
    .opCode      (inOp),
    .operandZero (accOr == 32'h0),
    .aReg        (aReg),
    .shiftCnt    (shiftCnt),
    .brkArmed    (brkArm_r),
    .highPri     (highPri),
    .timePast    (timePast),
    .chanReady   (chanReady),
    .fmulRound   (fmulRound),
    .cycles      (calcCy)
  );

  // ========================================
  // Sequencer
  always_comb
  begin
    stateNxt = state_r;
    unique case (state_r)
      ST_IDLE: if (issue) stateNxt = ST_EXEC;
      ST_EXEC:
        if (execEnd)
        begin
          if (haltSync_r && deschedPt_r) stateNxt = ST_HALT; // [RULE8]
          else if (isMove_r)             stateNxt = ST_MOVE;
          else                           stateNxt = ST_IDLE;
        end
      ST_MOVE:
        if (!mvGo || remNxt == 32'h0) stateNxt = ST_IDLE;
        else if (mvStop)             stateNxt = ST_SUSP;
      ST_SUSP: if (moveResume) stateNxt = ST_MOVE;
      ST_HALT: if (!haltSync_r) stateNxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
    if (!rstn)
    begin
      state_r      <= ST_IDLE;
      instrReady_r <= 1'b0;
      haltMeta_r   <= 1'b0;
      haltSync_r   <= 1'b0;
      halted_r     <= 1'b0;
    end
    else
    begin
      state_r      <= stateNxt;
      instrReady_r <= stateNxt == ST_IDLE;
      haltMeta_r   <= haltProbe;
      haltSync_r   <= haltMeta_r;
      halted_r     <= stateNxt == ST_HALT;
    end

  // Operand accumulator
  always_ff @(posedge mclk)
    if (!rstn)
      operandAcc_r <= 32'h0;
    else if (take && isPfx)
      operandAcc_r <= accOr << 4; // [RULE2] [RULE5]
    else if (take && isNfx)
      operandAcc_r <= (~accOr) << 4; // [RULE3]
    else if (issue)
      operandAcc_r <= 32'h0; // [RULE5]

  // Issue outputs
  always_ff @(posedge mclk)
    if (!rstn)
    begin
      execValid_r <= 1'b0;
      funcCode_r  <= 4'h0;
      operand_r   <= 32'h0;
      opCode_r    <= 12'h000;
      cycles_r    <= 8'h00;
      cnt_r       <= 8'h00;
      deschedPt_r <= 1'b0;
      brkSwap_r   <= 1'b0;
      isMove_r    <= 1'b0;
    end
    else
    begin
      execValid_r <= issue;
      brkSwap_r   <= issue && (j0Brk || isBreak); // [RULE10] [RULE12]
      if (issue)
      begin
        funcCode_r  <= inFunc;
        operand_r   <= accOr;
        opCode_r    <= inOpr ? inOp : 12'h000;
        cycles_r    <= calcCy;
        cnt_r       <= calcCy - 8'h01;
        deschedPt_r <= nDes; // [RULE7] [RULE11]
        isMove_r    <= inOpr && inOp == OP_MOVE;
      end
      else if (state_r == ST_EXEC && cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
    end

  // Flags: a set in the cycle of a clear wins
  always_ff @(posedge mclk)
    if (!rstn)
    begin
      done_r         <= 1'b0;
      processFault_r <= 1'b0;
      fpFault_r      <= 1'b0;
      brkArm_r       <= 1'b0;
    end
    else
    begin
      done_r         <= execEnd;
      processFault_r <= errSet || (processFault_r && !errClr); // [RULE9]
      fpFault_r      <= fpSet || (fpFault_r && !fpClr); // [RULE18] [RULE19]
      brkArm_r       <= brkOn || (brkArm_r && !brkOff); // [RULE10]
    end

  // Block move datapath
  always_ff @(posedge mclk)
    if (!rstn)
    begin
      mvRem_r         <= 32'h0;
      mvOff_r         <= 2'h0;
      mvLast_r        <= 3'h0;
      moveStep_r      <= 1'b0;
      moveBytes_r     <= 3'h0;
      moveRewrite_r   <= 1'b0;
      moveSuspended_r <= 1'b0;
    end
    else
    begin
      moveStep_r      <= mvGo;
      moveSuspended_r <= mvStop; // [RULE14]
      moveRewrite_r   <= resume && !moveSkipRewrite; // [RULE15]
      if (issue && inOpr && inOp == OP_MOVE)
      begin
        mvRem_r <= moveLen;
        mvOff_r <= moveDst;
      end
      else if (mvGo)
      begin
        mvRem_r     <= remNxt;
        mvOff_r     <= offNxt;
        mvLast_r    <= stepB;
        moveBytes_r <= stepB;
      end
      else if (resume)
        moveBytes_r <= mvLast_r; // [RULE15]
    end

  // ========================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_accClear;
    issue |=> operandAcc_r == 32'h0;
  endproperty
  a_accClear: assert property (p_accClear) else $error("accumulator not cleared"); // [RULE5]

  property p_pfxShift;
    take && isPfx |=> operandAcc_r == {$past(accOr[27:0]), 4'h0};
  endproperty
  a_pfxShift: assert property (p_pfxShift) else $error("prefix shift wrong"); // [RULE2]

  property p_nfxShift;
    take && isNfx |=> operandAcc_r == {~$past(accOr[27:0]), 4'h0};
  endproperty
  a_nfxShift: assert property (p_nfxShift) else $error("negative prefix wrong"); // [RULE3]

  property p_oprCode;
    issue && inOpr |=> opCode_r == $past(inOp) && funcCode_r == 4'hf;
  endproperty
  a_oprCode: assert property (p_oprCode) else $error("operate code wrong"); // [RULE4]

  property p_brzTime;
    issue && inFunc == `SCD_FN_BRZ |=> cycles_r == ($past(aReg == 32'h0) ? 8'h04 : 8'h02);
  endproperty
  a_brzTime: assert property (p_brzTime) else $error("branch cycles wrong"); // [RULE6]

  property p_jumpDes;
    issue && inFunc == `SCD_FN_J && !j0Brk |=> deschedPt_r && cycles_r == 8'h03;
  endproperty
  a_jumpDes: assert property (p_jumpDes) else $error("jump not descheduling"); // [RULE7]

  property p_haltAt;
    $rose(halted_r) |-> $past(deschedPt_r) && $past(state_r == ST_EXEC);
  endproperty
  a_haltAt: assert property (p_haltAt) else $error("halt off a descheduling point"); // [RULE8]

  property p_errSrc;
    processFault_r != $past(processFault_r) |-> $past(issue && nErr);
  endproperty
  a_errSrc: assert property (p_errSrc) else $error("process fault changed by other"); // [RULE9]

  property p_fpSrc;
    fpFault_r != $past(fpFault_r) |-> $past(issue && nFp);
  endproperty
  a_fpSrc: assert property (p_fpSrc) else $error("float fault changed by other"); // [RULE19]

  property p_fpChk;
    issue && inOpr && inOp == OP_FPCHK && fpFault_r |=> processFault_r;
  endproperty
  a_fpChk: assert property (p_fpChk) else $error("propagate missed"); // [RULE18]

  property p_j0Brk;
    issue && j0Brk |=> brkSwap_r ##0 cycles_r inside {8'h0b, 8'h0d};
  endproperty
  a_j0Brk: assert property (p_j0Brk) else $error("armed zero jump no swap"); // [RULE10]

  property p_brkNoDes;
    issue && isBreak |=> brkSwap_r && !deschedPt_r;
  endproperty
  a_brkNoDes: assert property (p_brkNoDes) else $error("break deschedules"); // [RULE11]

  property p_suspAlign;
    mvStop |=> moveSuspended_r && mvOff_r == 2'h0 && state_r == ST_SUSP;
  endproperty
  a_suspAlign: assert property (p_suspAlign) else $error("suspend off boundary"); // [RULE14]

  property p_rewrite;
    resume && !moveSkipRewrite |=> moveRewrite_r && moveBytes_r == mvLast_r;
  endproperty
  a_rewrite: assert property (p_rewrite) else $error("rewrite missing"); // [RULE15]

  c_j0Brk:  cover property (issue && j0Brk);
  c_susp:   cover property (moveSuspended_r);
  c_halt:   cover property ($rose(halted_r));
  c_fpProp: cover property (issue && inOpr && inOp == OP_FPCHK && fpFault_r);
endmodule
`default_nettype wire

// ---- design/scd_cfg.svh ----
// Constants for the stack processor instruction decoder.
// Assumes inclusion by bare name from the decoder sources.
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
// ========================================
// Function codes (upper nibble)
`define SCD_FN_J     4'h0
`define SCD_FN_PFIX  4'h2
`define SCD_FN_NFIX  4'h6
`define SCD_FN_ADC   4'h8
`define SCD_FN_BRZ   4'ha
`define SCD_FN_OPR   4'hf
// ========================================
// Cycle counts
`define SCD_CY_ONE     8'h01
`define SCD_CY_J       8'h03
`define SCD_CY_BRZ_NT  8'h02
`define SCD_CY_BRZ_T   8'h04
`define SCD_CY_TWT_F   8'h30
`define SCD_CY_TWT_P   8'h0f
`define SCD_CY_AWT_R   8'h05
`define SCD_CY_AWT_N   8'h11
`define SCD_CY_ENBC_R  8'h07
`define SCD_CY_ENBC_N  8'h05
`define SCD_CY_FMUL    8'h23
`define SCD_CY_FMUL_R  8'h28
`define SCD_CY_PROD_P  8'h04
`define SCD_CY_PROD_N  8'h05
`define SCD_CY_DSH_LO  8'h03
`define SCD_CY_DSH_HI  8'h1c
`define SCD_CY_SAVEH   8'h04
`define SCD_CY_J0B_H   8'h0b
`define SCD_CY_J0B_L   8'h0d
`define SCD_CY_BRK_H   8'h09
`define SCD_CY_BRK_L   8'h0b
`define SCD_DSH_SPLIT  7'h20
`endif

// ---- design/scd_pkg.sv ----
// Types for the stack processor instruction decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package scd_pkg;
  // ========================================
  // Operation codes
  typedef enum logic [11:0] {
    OP_ENDP = 12'h003, OP_ADD = 12'h005, OP_IN = 12'h007, OP_PROD = 12'h008,
    OP_OUT = 12'h00b, OP_SUB = 12'h00c, OP_STARTP = 12'h00d, OP_OUTB = 12'h00e,
    OP_OUTW = 12'h00f, OP_SETERR = 12'h010, OP_CSUB0 = 12'h013, OP_LADD = 12'h016,
    OP_LDIV = 12'h01a, OP_REM = 12'h01f, OP_LEND = 12'h021, OP_TESTERR = 12'h029,
    OP_TIN = 12'h02b, OP_DIV = 12'h02c, OP_DSHDN = 12'h035, OP_DSHUP = 12'h036,
    OP_LSUB = 12'h038, OP_SAVEH = 12'h03e, OP_ALTWT = 12'h044, OP_ENBC = 12'h048,
    OP_MOVE = 12'h04a, OP_CSNGL = 12'h04c, OP_CCNT1 = 12'h04d, OP_TALTWT = 12'h051,
    OP_MUL = 12'h053, OP_STOPERR = 12'h055, OP_CWORD = 12'h056, OP_FMUL = 12'h072,
    OP_FPCHK = 12'h083, OP_FPADD = 12'h087, OP_FPSUB = 12'h089, OP_FPMUL = 12'h08b,
    OP_FPDIV = 12'h08c, OP_FPREMF = 12'h08f, OP_FPGT = 12'h094, OP_FPEQ = 12'h095,
    OP_FPTEST = 12'h09c, OP_FPRTOI = 12'h09d, OP_FPINT = 12'h0a1, OP_FPLADDD = 12'h0a6,
    OP_FPLMULD = 12'h0a8, OP_FPLADDS = 12'h0aa, OP_FPENTRY = 12'h0ab, OP_FPLMULS = 12'h0ac,
    OP_BREAK = 12'h0b1, OP_BRKCLR = 12'h0b2, OP_BRKARM = 12'h0b3, OP_BRKTEST = 12'h0b4
  } scd_op_t;
  // ========================================
  // Float unit selector codes (low byte of A)
  typedef enum logic [7:0] {
    FS_SQRTF = 8'h01, FS_R32R64 = 8'h07, FS_R64R32 = 8'h08, FS_EXPDEC = 8'h09,
    FS_EXPINC = 8'h0a, FS_ABS = 8'h0b, FS_CHKI32 = 8'h0e, FS_CHKI64 = 8'h0f,
    FS_DIV2 = 8'h11, FS_MUL2 = 8'h12, FS_SETERR = 8'h23, FS_CLRERR = 8'h9c
  } scd_fsel_t;
  // ========================================
  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_EXEC = 5'b00010, ST_MOVE = 5'b00100,
    ST_SUSP = 5'b01000, ST_HALT = 5'b10000
  } scd_state_t;
endpackage

// ---- design/scd_cycle_calc.sv ----
// Cycle count of the instruction being issued.
// Assumes operands come from the datapath on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "scd_cfg.svh"
module scd_cycle_calc import scd_pkg::*; (
  // Instruction
  input  wire logic [3:0]  funcCode,
  input  wire logic [11:0] opCode,
  input  wire logic        operandZero,
  // Datapath conditions
  input  wire logic [31:0] aReg,
  input  wire logic [6:0]  shiftCnt,
  input  wire logic        brkArmed,
  input  wire logic        highPri,
  input  wire logic        timePast,
  input  wire logic        chanReady,
  input  wire logic        fmulRound,
  // Result
  output logic      [7:0]  cycles
);
  function automatic logic [7:0] msbIdx(input logic [31:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 32; i++)
      if (v[i]) r = 8'(i);
    return r;
  endfunction

  wire [31:0] aAbs   = aReg[31] ? (32'h0 - aReg) : aReg;
  wire [7:0]  prodCy = aReg[31] ? msbIdx(aAbs) + `SCD_CY_PROD_N : msbIdx(aReg) + `SCD_CY_PROD_P;
  wire [7:0]  nCnt   = {1'b0, shiftCnt};
  wire [7:0]  dshCy  = (shiftCnt < `SCD_DSH_SPLIT) ? nCnt + `SCD_CY_DSH_LO : nCnt - `SCD_CY_DSH_HI;
  wire        aZero  = aReg == 32'h0;

  always_comb
  begin
    cycles = `SCD_CY_ONE;
    if (funcCode == `SCD_FN_J)
    begin
      if (operandZero && brkArmed)
        cycles = highPri ? `SCD_CY_J0B_H : `SCD_CY_J0B_L;
      else
        cycles = `SCD_CY_J; // [RULE6]
    end
    else if (funcCode == `SCD_FN_BRZ)
      cycles = aZero ? `SCD_CY_BRZ_T : `SCD_CY_BRZ_NT; // [RULE6]
    else if (funcCode == `SCD_FN_OPR)
    begin
      case (opCode)
        OP_TALTWT: cycles = timePast ? `SCD_CY_TWT_P : `SCD_CY_TWT_F; // [RULE20]
        OP_ALTWT:  cycles = chanReady ? `SCD_CY_AWT_R : `SCD_CY_AWT_N; // [RULE21]
        OP_ENBC:   cycles = chanReady ? `SCD_CY_ENBC_R : `SCD_CY_ENBC_N; // [RULE22]
        OP_FMUL:   cycles = fmulRound ? `SCD_CY_FMUL_R : `SCD_CY_FMUL; // [RULE23]
        OP_PROD:   cycles = prodCy; // [RULE24]
        OP_DSHUP:  cycles = dshCy; // [RULE25]
        OP_DSHDN:  cycles = dshCy;
        OP_SAVEH:  cycles = `SCD_CY_SAVEH; // [RULE26]
        OP_BREAK:  cycles = highPri ? `SCD_CY_BRK_H : `SCD_CY_BRK_L;
        default:   cycles = `SCD_CY_ONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- bench/scd_fetch_model.sv ----
// Instruction fetch model: offers queued bytes to the decoder one at a time.
// Assumes the bench queues bytes with push; slow leaves a gap after each byte.
`timescale 1ns/10ps
`default_nettype none
module scd_fetch_model (
  // Fetch handshake
  input  wire logic       mclk,
  input  wire logic       instrReady_r,
  output var  logic       instrValid,
  output var  logic [7:0] instrByte
);
  // ========================================
  // Byte queue and presentation
  logic [7:0] q[$];
  logic       taken;
  logic       slow;
  initial
  begin
    instrValid = 1'b0;
    instrByte  = 8'h00;
    taken      = 1'b0;
    slow       = 1'b0;
  end
  always @(posedge mclk) taken = instrValid && instrReady_r;
  // An idle bus shows inverted data, so a stale byte never looks valid
  always @(negedge mclk)
  begin
    if (taken)
      void'(q.pop_front());
    instrValid <= q.size() > 0 && !(slow && taken);
    instrByte  <= (q.size() > 0 && !(slow && taken)) ? q[0] : ~instrByte;
    taken = 1'b0;
  end
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
endmodule
`default_nettype wire

// ---- bench/stack_cpu_instruction_decode_tb.sv ----
// Self-checking bench for the stack processor instruction decoder.
// Assumes scd_fetch_model feeds bytes; the bench drives all else at negedge.
`timescale 1ns/10ps
`default_nettype none
module stack_cpu_instruction_decode_tb import scd_pkg::*; ;
  typedef struct packed {logic [3:0] fc; logic [31:0] v; logic [7:0] cy; logic ds; logic sw;} scd_exp_t;
  logic        mclk, rstn, instrValid, instrReady_r, highPri, timePast, chanReady, fmulRound, aluErr;
  logic        fpExcept, fpNonFinite, haltProbe, moveIrq, moveResume, moveSkipRewrite, execValid_r;
  logic        deschedPt_r, brkSwap_r, done_r, halted_r, processFault_r, fpFault_r, brkArm_r;
  logic        moveStep_r, moveRewrite_r, moveSuspended_r;
  logic [7:0]  instrByte, cycles_r;
  logic [31:0] aReg, moveLen, operand_r;
  logic [6:0]  shiftCnt;
  logic [1:0]  moveDst;
  logic [3:0]  funcCode_r;
  logic [11:0] opCode_r;
  logic [2:0]  moveBytes_r;
  scd_exp_t    expq[$];
  logic [3:0]  stepq[$];
  logic [11:0] dsc[9] = '{12'h007, 12'h00b, 12'h00e, 12'h00f, 12'h02b, 12'h055, 12'h021, 12'h003, 12'h00d};
  int          failCount, nCompared, seed, k, n, doneDue;
  scd_fetch_model scd_fetch_model_inst (.mclk, .instrReady_r, .instrValid, .instrByte);
  scd_decoder scd_decoder_inst (.mclk, .rstn, .instrValid, .instrByte, .instrReady_r, .aReg, .shiftCnt,
    .highPri, .timePast, .chanReady, .fmulRound, .aluErr, .fpExcept, .fpNonFinite, .haltProbe, .moveLen,
    .moveDst, .moveIrq, .moveResume, .moveSkipRewrite, .execValid_r, .funcCode_r, .operand_r, .opCode_r,
    .cycles_r, .deschedPt_r, .brkSwap_r, .done_r, .halted_r, .processFault_r, .fpFault_r, .brkArm_r,
    .moveStep_r, .moveBytes_r, .moveRewrite_r, .moveSuspended_r);
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ========================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    nCompared++;
    if (got !== ex)
    begin
      failCount++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Idle means every queued byte, issue and move step has been seen
  task automatic waitReady();
    for (int i = 0; i < 400; i++)
    begin
      @(negedge mclk);
      if (expq.size() == 0 && stepq.size() == 0 && scd_fetch_model_inst.q.size() == 0 && instrReady_r === 1'b1)
        return;
    end
    chk("waitReady", 32'h1, 32'h0);
    printVerdict();
  endtask
  task automatic issue(input logic [3:0] fc, input logic [31:0] v, input logic [7:0] cy, input logic ds,
                       input logic sw);
    for (int i = 7; i > 0; i--)
      if ((v >> (4 * i)) != 0)
        scd_fetch_model_inst.push({4'h2, v[4*i+:4]});
    scd_fetch_model_inst.push({fc, v[3:0]});
    expq.push_back(scd_exp_t'{fc, v, cy, ds, sw});
    waitReady();
  endtask
  task automatic op(input logic [11:0] c, input logic [7:0] cy, input logic ds);
    issue(4'hf, {20'h0, c}, cy, ds, 1'b0);
  endtask
  task automatic fl(input logic [11:0] c, input logic pf, input logic ff);
    op(c, 8'h00, 1'b0);
    chk("faultFlags", {30'h0, pf, ff}, {30'h0, processFault_r, fpFault_r});
  endtask
  // Cycle count is skipped where the expectation is zero
  always @(posedge mclk)
  begin
    scd_exp_t e;
    logic [3:0] s;
    if (doneDue > 0)
    begin
      doneDue--;
      if (doneDue == 0)
        chk("done", 32'h1, {31'h0, done_r});
    end
    if (execValid_r === 1'b1)
    begin
      e = expq.pop_front();
      doneDue = e.cy;
      chk("funcCode", {28'h0, e.fc}, {28'h0, funcCode_r});
      chk("operand", e.v, operand_r);
      chk("opCode", {20'h0, (e.fc == 4'hf) ? e.v[11:0] : 12'h0}, {20'h0, opCode_r});
      chk("desched", {31'h0, e.ds}, {31'h0, deschedPt_r});
      chk("brkSwap", {31'h0, e.sw}, {31'h0, brkSwap_r});
      if (e.cy != 8'h00)
        chk("cycles", {24'h0, e.cy}, {24'h0, cycles_r});
    end
    if (moveStep_r === 1'b1 || moveRewrite_r === 1'b1)
    begin
      s = stepq.pop_front();
      chk("moveStep", {28'h0, s}, {28'h0, moveRewrite_r, moveBytes_r});
    end
  end
  // ========================================
  // Main sequence
  initial
  begin
    {rstn, highPri, timePast, chanReady, fmulRound, aluErr, fpExcept, fpNonFinite, haltProbe} = '0;
    {moveIrq, moveResume, moveSkipRewrite, aReg, moveLen, shiftCnt, moveDst} = '0;
    failCount = 0;
    nCompared = 0;
    seed = 92;
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    issue(4'h4, 32'h987, 8'h01, 1'b0, 1'b0);
    op(12'h016, 8'h00, 1'b0);
    expq.push_back(scd_exp_t'{4'h4, 32'hffffffe1, 8'h01, 1'b0, 1'b0});
    scd_fetch_model_inst.push(8'h61);
    scd_fetch_model_inst.push(8'h41);
    waitReady();
    scd_fetch_model_inst.slow = 1'b1;
    repeat (6)
      issue(4'h4, $unsigned($random(seed)) >> (1 + $unsigned($random(seed)) % 31), 8'h01, 1'b0, 1'b0);
    scd_fetch_model_inst.slow = 1'b0;
    $display("test encoding done");
    for (k = 0; k < 2; k++)
    begin
      aReg = k ? 32'h5 : 32'h0;
      issue(4'ha, 32'h3, k ? 8'h02 : 8'h04, 1'b0, 1'b0);
      timePast = k[0];
      op(12'h051, k ? 8'h0f : 8'h30, 1'b1);
      chanReady = k[0];
      op(12'h044, k ? 8'h05 : 8'h11, 1'b1);
      op(12'h048, k ? 8'h07 : 8'h05, 1'b0);
      fmulRound = k[0];
      op(12'h072, k ? 8'h28 : 8'h23, 1'b0);
      aReg = k ? 32'hfffffff0 : 32'h100;
      op(12'h008, k ? 8'h09 : 8'h0c, 1'b0);
      shiftCnt = k ? 7'h28 : 7'h05;
      op(12'h036, k ? 8'h0c : 8'h08, 1'b0);
      highPri = k[0];
      issue(4'h0, 32'h0, 8'h03, 1'b1, 1'b0);
      op(12'h0b3, 8'h01, 1'b0);
      chk("brkArm", 32'h1, {31'h0, brkArm_r});
      issue(4'h0, 32'h0, k ? 8'h0b : 8'h0d, 1'b1, 1'b1);
      issue(4'hf, 32'hb1, k ? 8'h09 : 8'h0b, 1'b0, 1'b1);
      op(12'h0b2, 8'h01, 1'b0);
      chk("brkArm", 32'h0, {31'h0, brkArm_r});
    end
    op(12'h03e, 8'h04, 1'b0);
    foreach (dsc[i])
      op(dsc[i], 8'h00, 1'b1);
    $display("test timing done");
    aluErr = 1'b1;
    fl(12'h046, 1'b0, 1'b0);
    fl(12'h005, 1'b1, 1'b0);
    aluErr = 1'b0;
    fl(12'h029, 1'b0, 1'b0);
    fpNonFinite = 1'b1;
    fl(12'h046, 1'b0, 1'b0);
    fl(12'h08b, 1'b0, 1'b1);
    fpNonFinite = 1'b0;
    fl(12'h083, 1'b1, 1'b1);
    fl(12'h09c, 1'b1, 1'b0);
    fl(12'h029, 1'b0, 1'b0);
    fl(12'h083, 1'b0, 1'b0);
    fpExcept = 1'b1;
    fl(12'h087, 1'b0, 1'b1);
    fpExcept = 1'b0;
    aReg = 32'h9c;
    fl(12'h0ab, 1'b0, 1'b0);
    aReg = 32'h23;
    fl(12'h0ab, 1'b0, 1'b1);
    $display("test flags done");
    haltProbe = 1'b1;
    op(12'h046, 8'h00, 1'b0);
    chk("halted", 32'h0, {31'h0, halted_r});
    fork
      issue(4'h0, 32'h2, 8'h03, 1'b1, 1'b0);
      begin
        for (n = 0; n < 200 && halted_r !== 1'b1; n++) @(negedge mclk);
        chk("halted", 32'h1, {31'h0, halted_r});
        haltProbe = 1'b0;
      end
    join
    $display("test halt done");
    moveLen = 32'd6;
    moveDst = 2'd2;
    stepq = '{4'h2, 4'h4};
    op(12'h04a, 8'h01, 1'b0);
    for (k = 0; k < 2; k++)
    begin
      moveLen = 32'd12;
      moveDst = 2'd1;
      moveIrq = 1'b1;
      stepq = '{4'h3, 4'hb, 4'h4, 4'h4, 4'h1};
      if (k != 0)
        stepq.delete(1);
      fork
        op(12'h04a, 8'h01, 1'b0);
        begin
          for (n = 0; n < 200 && moveSuspended_r !== 1'b1; n++) @(negedge mclk);
          chk("moveSuspended", 32'h1, {31'h0, moveSuspended_r});
          moveIrq = 1'b0;
          moveSkipRewrite = k[0];
          moveResume = 1'b1;
          @(negedge mclk);
          moveResume = 1'b0;
        end
      join
    end
    $display("test move done");
    printVerdict();
  end
endmodule
`default_nettype wire
